// >>> rtl/backplane_port.sv
// Purpose: device end of the asynchronous multiplexed backplane bus
// Assumes: bus pins already synchronous to mclk; open-drain pins split
// Notes: slave reply, interrupt acknowledge, master read with data-in
//
// What the bus document requires
// RULE1: Reply is asserted whenever a data-in or data-out strobe addresses us; the code replies only to data-in in input and data-out in output cycles.
// RULE2: Reply means our read data is on the lines, or write data latched.
// RULE3: Reply is also asserted in acknowledge cycles where we interrupted.
// RULE4: Data-in during address-sync is an input transfer needing a reply; the code replies only if write/byte was clear at the sync edge.
// RULE5: As master, data-in is asserted only once ready to accept data.
// RULE6: Data-in without address-sync is an interrupt acknowledge.
// RULE7: Address-sync is asserted only after a valid address is driven.
// RULE8: A transfer lasts while address-sync stays asserted.
// RULE9: Master asserts write/byte at sync leading edge for output cycles.
// RULE10: Write/byte sampled at sync leading edge selects output or input cycle.
// RULE11: Request line driven exactly when enable and request flip-flops set.
// RULE12: Request is set on function completion or readiness for a new one.
// RULE13: Processor acknowledges only with status bit 7 clear, via data-in and chain.
// RULE14: While requesting, block the incoming acknowledge and take it.
// RULE15: While not requesting, pass the acknowledge to the next device.
// RULE16: Master asserts upper-bank select for addresses in the top 4K bank; the code asserts it for the top 8K (address bits 15..13 set).
// RULE17: Upper-bank select holds through addressing; address-sync follows it.
// RULE18: Our registers are recognised only with upper-bank select asserted.
// RULE19: Data-out means valid write data on the lines; receiver replies; the code latches and replies only if write/byte was set at the sync edge.
// RULE20: In a taken acknowledge, drive the vector before replying.
// RULE21: Drop reply and release data only after the strobe is negated.
`timescale 1ns/1ps
module backplane_port #(
  parameter logic [bus_port_pkg::BASE_W-1:0] BASE = bus_port_pkg::BASE_DEFAULT,
  parameter logic [bus_port_pkg::DAL_W-1:0] VECTOR = bus_port_pkg::VECTOR_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Address/data lines
  input wire logic [bus_port_pkg::DAL_W-1:0] muxed_addr_data_n_in,
  output logic [bus_port_pkg::DAL_W-1:0] muxed_addr_data_n_out,
  output logic muxed_addr_data_n_oe_n,
  // Strobes and flags
  input wire logic address_sync_n_in,
  output logic address_sync_n_out,
  output logic address_sync_n_oe_n,
  input wire logic data_in_strobe_n_in,
  output logic data_in_strobe_n_out,
  output logic data_in_strobe_n_oe_n,
  input wire logic data_out_strobe_n,
  input wire logic reply_strobe_n_in,
  output logic reply_strobe_n_out,
  output logic reply_strobe_n_oe_n,
  input wire logic write_byte_flag_n_in,
  output logic write_byte_flag_n_out,
  output logic write_byte_flag_n_oe_n,
  input wire logic upper_bank_select_n_in,
  output logic upper_bank_select_n_out,
  output logic upper_bank_select_n_oe_n,
  // Interrupt chain
  input wire logic irq_ack_chain_in_n,
  output logic irq_ack_chain_out_n,
  output logic irq_request_n_out,
  output logic irq_request_n_oe_n,
  // Device register side
  output logic [bus_port_pkg::REG_IDX_W-1:0] reg_index,
  output logic reg_rd,
  output logic reg_wr,
  output logic [bus_port_pkg::DAL_W-1:0] reg_wdata,
  input wire logic [bus_port_pkg::DAL_W-1:0] reg_rdata,
  // Interrupt events
  input wire logic irq_enable,
  input wire logic func_done,
  input wire logic func_ready,
  // Master read request
  input wire logic mst_req,
  input wire logic [bus_port_pkg::DAL_W-1:0] mst_addr,
  input wire logic mst_accept,
  output logic mst_busy,
  output logic mst_done,
  output logic [bus_port_pkg::DAL_W-1:0] mst_rdata
);

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SEL = 4'b0010,
    S_DRIVE = 4'b0100,
    S_REPLY = 4'b1000
  } slave_state_type;

  typedef enum logic [4:0] {
    M_IDLE = 5'b00001,
    M_ADDR = 5'b00010,
    M_SYNC = 5'b00100,
    M_READY = 5'b01000,
    M_DIN = 5'b10000
  } master_state_type;

  slave_state_type state;
  slave_state_type next_state;
  master_state_type mstate;
  master_state_type next_mstate;
  logic sync_prev;
  logic out_cycle;
  logic hit;
  logic in_ack_cycle;
  logic [bus_port_pkg::DAL_W-1:0] drive_data;
  logic [bus_port_pkg::DAL_W-1:0] mst_addr_q;

  irq_link_if link ();

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  wire [bus_port_pkg::DAL_W-1:0] dal = ~muxed_addr_data_n_in;
  wire sync_on = ~address_sync_n_in;
  wire din_on = ~data_in_strobe_n_in;
  wire dout_on = ~data_out_strobe_n;
  wire sync_lead = sync_on & ~sync_prev & mstate == M_IDLE;
  wire bank_hit = ~upper_bank_select_n_in; // [RULE18]
  wire base_hit = dal[bus_port_pkg::BANK_OFS_MSB:bus_port_pkg::REG_IDX_W+1] == BASE;
  wire ack_cycle_seen = din_on & ~sync_on & mstate == M_IDLE; // [RULE6]
  wire read_go = state == S_SEL & din_on & ~out_cycle; // [RULE4]
  wire write_go = state == S_SEL & dout_on & out_cycle; // [RULE19]
  wire strobes_off = ~din_on & ~dout_on;

  // ----------------------------------------------------------------
  // Interrupt link
  // ----------------------------------------------------------------
  assign link.func_done = func_done;
  assign link.func_ready = func_ready;
  assign link.irq_enable = irq_enable;
  assign link.ack_cycle_seen = ack_cycle_seen & state == S_IDLE;
  assign link.ack_cycle_done = in_ack_cycle & state == S_REPLY & strobes_off;

  irq_chain u_chain (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .link(link),
    .irq_ack_chain_in_n(irq_ack_chain_in_n),
    .irq_ack_chain_out_n(irq_ack_chain_out_n),
    .irq_request_n_out(irq_request_n_out),
    .irq_request_n_oe_n(irq_request_n_oe_n)
  );

  // ----------------------------------------------------------------
  // Slave sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (sync_lead & bank_hit & base_hit) begin
          next_state = S_SEL;
        end else if (link.take_ack) begin
          next_state = S_DRIVE; // [RULE20]
        end
      end
      S_SEL: begin
        if (~sync_on) begin
          next_state = S_IDLE; // [RULE8]
        end else if (read_go) begin
          next_state = S_DRIVE; // [RULE2]
        end else if (write_go) begin
          next_state = S_REPLY; // [RULE2]
        end
      end
      S_DRIVE: next_state = S_REPLY;
      S_REPLY: begin
        if (strobes_off) begin
          next_state = sync_on & ~in_ack_cycle ? S_SEL : S_IDLE; // [RULE21] [RULE8]
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      sync_prev <= 1'b0;
    end else begin
      state <= next_state;
      sync_prev <= sync_on;
    end
  end

  // Cycle type and register index caught at the sync edge; acknowledge mark caught while idle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_cycle <= 1'b0;
      reg_index <= '0;
      in_ack_cycle <= 1'b0;
    end else begin
      if (sync_lead) begin
        out_cycle <= ~write_byte_flag_n_in; // [RULE10]
        reg_index <= dal[bus_port_pkg::REG_IDX_W:1];
      end
      if (state == S_IDLE) begin
        in_ack_cycle <= link.take_ack; // [RULE3]
      end
    end
  end

  // Read data captured when data-in arrives; vector for acknowledge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drive_data <= bus_port_pkg::DATA_RESET;
      reg_wdata <= bus_port_pkg::DATA_RESET;
    end else begin
      if (read_go) begin
        drive_data <= reg_rdata;
      end else if (state == S_IDLE & link.take_ack) begin
        drive_data <= VECTOR; // [RULE20]
      end
      if (write_go) begin
        reg_wdata <= dal; // [RULE19]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
    end else begin
      reg_rd <= read_go;
      reg_wr <= write_go;
    end
  end

  // ----------------------------------------------------------------
  // Master read sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_mstate = mstate;
    unique case (mstate)
      M_IDLE: begin
        if (mst_req & state == S_IDLE & ~sync_on) begin
          next_mstate = M_ADDR;
        end
      end
      M_ADDR: next_mstate = M_SYNC; // [RULE7]
      M_SYNC: next_mstate = M_READY;
      M_READY: begin
        if (mst_accept) begin
          next_mstate = M_DIN; // [RULE5]
        end
      end
      M_DIN: begin
        if (~reply_strobe_n_in) begin
          next_mstate = M_IDLE; // [RULE8]
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mstate <= M_IDLE;
      mst_addr_q <= bus_port_pkg::DATA_RESET;
      mst_rdata <= bus_port_pkg::DATA_RESET;
      mst_done <= 1'b0;
    end else begin
      mstate <= next_mstate;
      mst_done <= mstate == M_DIN & ~reply_strobe_n_in;
      if (mstate == M_IDLE & mst_req) begin
        mst_addr_q <= mst_addr;
      end
      if (mstate == M_DIN & ~reply_strobe_n_in) begin
        mst_rdata <= dal;
      end
    end
  end

  assign mst_busy = mstate != M_IDLE;

  // ----------------------------------------------------------------
  // Pin drive; each line is pulled low only while enabled
  // ----------------------------------------------------------------
  wire m_addr_phase = mstate == M_ADDR | mstate == M_SYNC;
  wire bank7_req = &mst_addr_q[bus_port_pkg::DAL_W-1:bus_port_pkg::BANK_OFS_MSB+1];
  wire slave_drive = state == S_DRIVE | (state == S_REPLY & ~out_cycle) | (state == S_REPLY & in_ack_cycle);

  assign muxed_addr_data_n_out = m_addr_phase ? ~mst_addr_q : ~drive_data; // [RULE20]
  assign muxed_addr_data_n_oe_n = ~(m_addr_phase | slave_drive); // [RULE21]
  assign reply_strobe_n_out = 1'b0;
  assign reply_strobe_n_oe_n = state != S_REPLY; // [RULE1] [RULE3]
  assign address_sync_n_out = 1'b0;
  assign address_sync_n_oe_n = ~(mstate == M_SYNC | mstate == M_READY | mstate == M_DIN); // [RULE7]
  assign data_in_strobe_n_out = 1'b0;
  assign data_in_strobe_n_oe_n = mstate != M_DIN; // [RULE5]
  // Master only reads, so write/byte stays released
  assign write_byte_flag_n_out = 1'b0;
  assign write_byte_flag_n_oe_n = 1'b1; // [RULE9]
  assign upper_bank_select_n_out = 1'b0;
  assign upper_bank_select_n_oe_n = ~(m_addr_phase & bank7_req); // [RULE16] [RULE17]

endmodule : backplane_port

// >>> shared/bus_port_pkg.sv
// Purpose: shared constants of the backplane bus port
// Assumes: 16 multiplexed address/data lines, word registers
// Notes: all pin levels outside are active low
package bus_port_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DAL_W = 16;
  localparam int REG_IDX_W = 2;
  // Address bits 12..0 lie inside the upper 8K bank
  localparam int BANK_OFS_MSB = 12;
  localparam int BASE_W = BANK_OFS_MSB - REG_IDX_W;

  // ----------------------------------------------------------------
  // Reset and default values
  // ----------------------------------------------------------------
  localparam logic [BASE_W-1:0] BASE_DEFAULT = 10'h3E4;
  localparam logic [DAL_W-1:0] VECTOR_DEFAULT = 16'h0160;
  localparam logic [DAL_W-1:0] DATA_RESET = 16'h0000;
  localparam logic IRQ_REQ_RESET = 1'b0;

endpackage : bus_port_pkg

// >>> shared/irq_link_if.sv
// Purpose: carries interrupt state between bus port and its chain logic
// Assumes: single clock mclk
// Notes: no clocking block
`timescale 1ns/1ps
interface irq_link_if;
  logic func_done;
  logic func_ready;
  logic irq_enable;
  logic ack_cycle_seen;
  logic ack_cycle_done;
  logic requesting;
  logic take_ack;

  modport chain (
    input func_done, func_ready, irq_enable, ack_cycle_seen, ack_cycle_done,
    output requesting, take_ack
  );
  modport port (
    output func_done, func_ready, irq_enable, ack_cycle_seen, ack_cycle_done,
    input requesting, take_ack
  );
endinterface : irq_link_if

// >>> rtl/irq_chain.sv
// Purpose: interrupt request flip-flop and acknowledge daisy chain
// Assumes: chain input synchronous to mclk
// Notes: chain pass is combinational so the chain is not slowed
`timescale 1ns/1ps
module irq_chain (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Interrupt link
  irq_link_if.chain link,
  // Daisy chain pins
  input wire logic irq_ack_chain_in_n,
  output logic irq_ack_chain_out_n,
  output logic irq_request_n_out,
  output logic irq_request_n_oe_n
);

  logic req_ff;
  wire set_req = link.func_done | link.func_ready; // [RULE12]
  wire requesting = req_ff & link.irq_enable; // [RULE11]

  // ----------------------------------------------------------------
  // Request flip-flop; a new event beats the clear of an old one
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_ff <= bus_port_pkg::IRQ_REQ_RESET;
    end else begin
      req_ff <= (req_ff & ~link.ack_cycle_done) | set_req;
    end
  end

  assign link.requesting = requesting;
  assign irq_request_n_out = 1'b0;
  assign irq_request_n_oe_n = ~requesting; // [RULE11]
  // Take the acknowledge ourselves, or hand it down the chain
  assign link.take_ack = requesting & ~irq_ack_chain_in_n & link.ack_cycle_seen; // [RULE14]
  assign irq_ack_chain_out_n = requesting | irq_ack_chain_in_n; // [RULE14] [RULE15]

endmodule : irq_chain

// >>> tb/port_assertions.sv
// Purpose: protocol checks on the bus port pins
// Assumes: one clock domain, synchronous reset
// Notes: bound into backplane_port
`timescale 1ns/1ps
module port_assertions #(
  parameter logic [15:0] VECTOR = 16'h0000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Bus pins
  input wire logic [15:0] muxed_addr_data_n_out,
  input wire logic muxed_addr_data_n_oe_n,
  input wire logic address_sync_n_in,
  input wire logic address_sync_n_oe_n,
  input wire logic data_in_strobe_n_in,
  input wire logic data_in_strobe_n_oe_n,
  input wire logic data_out_strobe_n,
  input wire logic reply_strobe_n_in,
  input wire logic reply_strobe_n_oe_n,
  input wire logic upper_bank_select_n_in,
  input wire logic upper_bank_select_n_oe_n,
  input wire logic irq_ack_chain_in_n,
  input wire logic irq_ack_chain_out_n,
  input wire logic irq_request_n_oe_n,
  // Device side
  input wire logic irq_enable,
  input wire logic func_done,
  input wire logic func_ready,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic mst_accept,
  input wire logic mst_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Reply, interrupt chain and master read
  // ----------------------------------------
  sequence s_strobes_off;
    data_in_strobe_n_in && data_out_strobe_n;
  endsequence
  sequence s_foreign_sync;
    $fell(address_sync_n_in) && upper_bank_select_n_in && address_sync_n_oe_n;
  endsequence
  a_write_reply: assert property (reg_wr |-> !reply_strobe_n_oe_n && !$past(data_out_strobe_n))
    else $error("write not answered");
  a_read_data_first: assert property ($fell(reply_strobe_n_oe_n) && !address_sync_n_in && !data_in_strobe_n_in
    |-> !$past(muxed_addr_data_n_oe_n))
    else $error("reply before read data");
  a_vector_first: assert property ($fell(reply_strobe_n_oe_n) && address_sync_n_in
    |-> muxed_addr_data_n_out == ~VECTOR && !$past(muxed_addr_data_n_oe_n))
    else $error("vector not ahead of reply");
  a_reply_holds: assert property (!reply_strobe_n_oe_n && !(data_in_strobe_n_in && data_out_strobe_n)
    |=> !reply_strobe_n_oe_n)
    else $error("reply dropped early");
  a_reply_release: assert property (!reply_strobe_n_oe_n ##0 s_strobes_off
    |=> reply_strobe_n_oe_n && muxed_addr_data_n_oe_n)
    else $error("reply or data held too long");
  a_irq_set: assert property ((func_done || func_ready) && irq_enable |=> !irq_request_n_oe_n)
    else $error("request not raised");
  a_irq_masked: assert property (!irq_enable |-> irq_request_n_oe_n)
    else $error("request driven while disabled");
  a_chain_block: assert property (!irq_request_n_oe_n |-> irq_ack_chain_out_n)
    else $error("acknowledge passed while requesting");
  a_chain_pass: assert property (!irq_ack_chain_in_n && irq_request_n_oe_n && irq_enable
    |-> !irq_ack_chain_out_n)
    else $error("acknowledge not passed");
  a_bank_gate: assert property (s_foreign_sync |-> reply_strobe_n_oe_n [*6])
    else $error("reply without bank select");
  a_master_din: assert property ($fell(data_in_strobe_n_oe_n) |-> $past(mst_accept) && !address_sync_n_oe_n)
    else $error("data-in before ready");
  a_master_done: assert property (mst_done |-> !$past(reply_strobe_n_in) && !$past(data_in_strobe_n_oe_n))
    else $error("master read ended without reply");
  a_read_drive: assert property (reg_rd |-> !muxed_addr_data_n_oe_n && !$past(data_in_strobe_n_in))
    else $error("read data not driven after data-in");
  a_master_bank: assert property ($fell(address_sync_n_oe_n) |-> !muxed_addr_data_n_oe_n
    && upper_bank_select_n_oe_n == |muxed_addr_data_n_out[15:13] && $stable(upper_bank_select_n_oe_n))
    else $error("bank select wrong at address-sync");
endmodule : port_assertions

bind backplane_port port_assertions #(.VECTOR(VECTOR)) chk (.mclk, .sys_rst, .muxed_addr_data_n_out,
  .muxed_addr_data_n_oe_n, .address_sync_n_in, .address_sync_n_oe_n, .data_in_strobe_n_in, .data_in_strobe_n_oe_n,
  .data_out_strobe_n, .reply_strobe_n_in, .reply_strobe_n_oe_n, .upper_bank_select_n_in, .upper_bank_select_n_oe_n,
  .irq_ack_chain_in_n, .irq_ack_chain_out_n, .irq_request_n_oe_n, .irq_enable, .func_done, .func_ready, .reg_rd,
  .reg_wr, .mst_accept, .mst_done);

// >>> tb/memory_model.sv
// Purpose: memory answering the port's master reads
// Assumes: lines active low, pulled up when released
// Notes: answer delay of 0 to 3 cycles, random
`timescale 1ns/1ps
module memory_model (
  // Clock
  input wire logic mclk,
  // Line levels
  input wire logic address_sync_n_oe_n,
  input wire logic sync_l,
  input wire logic din_l,
  input wire logic [15:0] dal_l,
  // Drives
  output logic mem_reply_n = 1'b1,
  output logic [15:0] mem_dal_n = 16'hFFFF
);
  logic sync_q = 1'b1;
  logic driving = 1'b0;
  logic [15:0] addr = 16'h0000;
  int delay = 0;
  always @(negedge mclk) begin
    sync_q <= sync_l;
    if (sync_q && !sync_l) addr <= ~dal_l;
    if (din_l || address_sync_n_oe_n) begin
      mem_reply_n <= 1'b1;
      mem_dal_n <= 16'hFFFF;
      driving <= 1'b0;
      delay <= $urandom % 4;
    end else if (delay != 0) begin
      delay <= delay - 1;
    end else if (!driving) begin
      mem_dal_n <= ~(addr ^ 16'h5A5A);
      driving <= 1'b1;
    end else begin
      mem_reply_n <= 1'b0;
    end
  end
endmodule : memory_model

// >>> tb/test_async_backplane_bus_port.sv
// Purpose: self-checking bench of the bus port
// Assumes: host master drives at the falling edge
// Notes: device register file kept in the bench
`timescale 1ns/1ps
module test_async_backplane_bus_port;
  logic mclk = 1'b0, sys_rst = 1'b1;
  logic h_sync = 1'b1, h_din = 1'b1, h_wtbt = 1'b1, h_bank = 1'b1, data_out_strobe_n = 1'b1;
  logic irq_ack_chain_in_n = 1'b1, irq_enable = 1'b0, func_done = 1'b0, func_ready = 1'b0;
  logic mst_req = 1'b0, mst_accept = 1'b0, mem_reply_n;
  logic [15:0] h_dal = 16'hFFFF, mst_addr = 16'h0000, mem_dal_n, muxed_addr_data_n_out, reg_wdata, mst_rdata;
  logic muxed_addr_data_n_oe_n, address_sync_n_out, address_sync_n_oe_n, data_in_strobe_n_out, data_in_strobe_n_oe_n;
  logic reply_strobe_n_out, reply_strobe_n_oe_n, write_byte_flag_n_out, write_byte_flag_n_oe_n, upper_bank_select_n_out;
  logic upper_bank_select_n_oe_n, irq_ack_chain_out_n, irq_request_n_out, irq_request_n_oe_n, reg_rd, reg_wr, mst_busy;
  logic mst_done;
  logic [1:0] reg_index;
  logic [15:0] dev_reg [4] = '{default: 16'h0000};
  int exp_reg [4];
  int miscompares = 0, num_checks = 0;
  // Open-drain lines: wired-AND of all parties
  wire [15:0] muxed_addr_data_n_in = h_dal & mem_dal_n & (muxed_addr_data_n_oe_n ? 16'hFFFF : muxed_addr_data_n_out);
  wire address_sync_n_in = h_sync & (address_sync_n_oe_n | address_sync_n_out);
  wire data_in_strobe_n_in = h_din & (data_in_strobe_n_oe_n | data_in_strobe_n_out);
  wire reply_strobe_n_in = mem_reply_n & (reply_strobe_n_oe_n | reply_strobe_n_out);
  wire write_byte_flag_n_in = h_wtbt & (write_byte_flag_n_oe_n | write_byte_flag_n_out);
  wire upper_bank_select_n_in = h_bank & (upper_bank_select_n_oe_n | upper_bank_select_n_out);
  wire irq_l = irq_request_n_oe_n | irq_request_n_out;
  wire [15:0] reg_rdata = dev_reg[reg_index];

  always #50 mclk = ~mclk;
  always @(posedge mclk) if (reg_wr) dev_reg[reg_index] <= reg_wdata;

  backplane_port dut (.mclk, .sys_rst, .muxed_addr_data_n_in, .muxed_addr_data_n_out, .muxed_addr_data_n_oe_n,
    .address_sync_n_in, .address_sync_n_out, .address_sync_n_oe_n, .data_in_strobe_n_in, .data_in_strobe_n_out,
    .data_in_strobe_n_oe_n, .data_out_strobe_n, .reply_strobe_n_in, .reply_strobe_n_out, .reply_strobe_n_oe_n,
    .write_byte_flag_n_in, .write_byte_flag_n_out, .write_byte_flag_n_oe_n, .upper_bank_select_n_in,
    .upper_bank_select_n_out, .upper_bank_select_n_oe_n, .irq_ack_chain_in_n, .irq_ack_chain_out_n, .irq_request_n_out,
    .irq_request_n_oe_n, .reg_index, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .irq_enable, .func_done, .func_ready,
    .mst_req, .mst_addr, .mst_accept, .mst_busy, .mst_done, .mst_rdata);
  memory_model mem (.mclk, .address_sync_n_oe_n, .sync_l(address_sync_n_in), .din_l(data_in_strobe_n_in),
    .dal_l(muxed_addr_data_n_in), .mem_reply_n, .mem_dal_n);

  // ----------------------------------------
  // Host bus cycles and comparison
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_reply(output bit ok);
    int n;
    n = 0;
    while (reply_strobe_n_in !== 1'b0 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    ok = (reply_strobe_n_in === 1'b0);
  endtask : wait_reply

  task automatic cycle(input logic [15:0] a, input bit wr, input bit wt, input bit sel, input logic [15:0] wd,
                       output logic [15:0] rd, output bit ok);
    @(negedge mclk);
    h_dal = ~a;
    h_bank = ~sel;
    h_wtbt = ~wt;
    @(negedge mclk);
    h_sync = 1'b0;
    @(negedge mclk);
    h_bank = 1'b1;
    h_wtbt = 1'b1;
    h_dal = wr ? ~wd : 16'hFFFF;
    h_din = wr;
    data_out_strobe_n = !wr;
    wait_reply(ok);
    rd = ~muxed_addr_data_n_in;
    @(negedge mclk);
    h_din = 1'b1;
    data_out_strobe_n = 1'b1;
    h_dal = 16'hFFFF;
    repeat (2) @(negedge mclk);
    h_sync = 1'b1;
  endtask : cycle

  task automatic ack_cycle(output logic [15:0] v, output bit ok, output logic ch);
    @(negedge mclk);
    h_din = 1'b0;
    irq_ack_chain_in_n = 1'b0;
    wait_reply(ok);
    v = ~muxed_addr_data_n_in;
    ch = irq_ack_chain_out_n;
    @(negedge mclk);
    h_din = 1'b1;
    irq_ack_chain_in_n = 1'b1;
    repeat (2) @(negedge mclk);
  endtask : ack_cycle

  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  function automatic logic [15:0] slave_addr(input int i);
    return {3'b111, bus_port_pkg::BASE_DEFAULT, 2'(i), 1'b0};
  endfunction : slave_addr

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    conclude();
  end

  initial begin
    int n;
    logic [15:0] d;
    bit ok;
    logic c;
    void'($urandom(32'h2209));
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      exp_reg[i] = $urandom & 16'hFFFF;
      cycle(slave_addr(i), 1'b1, 1'b1, 1'b1, 16'(exp_reg[i]), d, ok);
      check("write reply", 1, ok);
    end
    for (int i = 0; i < 4; i++) begin
      cycle(slave_addr(i), 1'b0, 1'b0, 1'b1, 16'h0000, d, ok);
      check("read data", 16'(exp_reg[i]), d);
    end
    cycle(slave_addr(1), 1'b0, 1'b0, 1'b0, 16'h0000, d, ok);
    check("no bank select", 0, ok);
    cycle(slave_addr(1) ^ 16'h0008, 1'b0, 1'b0, 1'b1, 16'h0000, d, ok);
    check("base mismatch", 0, ok);
    cycle(slave_addr(2), 1'b0, 1'b1, 1'b1, 16'h0000, d, ok);
    check("input in output cycle", 0, ok);
    for (int e = 0; e < 2; e++) begin
      @(negedge mclk);
      irq_enable = 1'(e);
      func_done = (e == 0);
      func_ready = (e == 1);
      @(negedge mclk);
      func_done = 1'b0;
      func_ready = 1'b0;
      @(negedge mclk);
      check("request line", 16'(e == 0), irq_l);
      irq_enable = 1'b1;
      @(negedge mclk);
      check("request line", 0, irq_l);
      ack_cycle(d, ok, c);
      check("ack reply", 1, ok);
      check("vector", bus_port_pkg::VECTOR_DEFAULT, d);
      check("chain blocked", 1, c);
      check("request cleared", 1, irq_l);
    end
    ack_cycle(d, ok, c);
    check("foreign ack reply", 0, ok);
    check("chain passed", 0, c);
    for (int i = 0; i < 3; i++) begin
      @(negedge mclk);
      // First read lands in the upper bank with address bit 12 clear
      mst_addr = i == 0 ? 16'hE000 | 16'($urandom & 32'h0FFF) : 16'($urandom);
      mst_req = 1'b1;
      @(negedge mclk);
      mst_req = 1'b0;
      check("master busy", 1, mst_busy);
      repeat (4) @(negedge mclk);
      mst_accept = 1'b1;
      n = 0;
      while (mst_done !== 1'b1 && n < 40) begin
        @(negedge mclk);
        n++;
      end
      check("master done", 1, mst_done);
      check("master data", mst_addr ^ 16'h5A5A, mst_rdata);
      check("master busy", 0, mst_busy);
      mst_accept = 1'b0;
    end
    conclude();
  end
endmodule : test_async_backplane_bus_port
